// File: rtm_core.sv
// Register bank for RF synthesizer, gain, power and trim settings, plus the
// locked test-mode controller with override, test-mux and pad re-route logic.
// Assumes one 25 MHz clock; oscillator clocks and pins are sampled as
// synchronous inputs.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps

// What this block does
// - Only exact key 0x5ECEC0DE unlocks test state
// - Key ignored unless test-access pin high
// - Test registers writable only pin high, unlocked
// - Pre-enable bits 10,8,7,6,5,3..0 per function
// - Override value bits share pre-enable positions
// - Override applies only unlocked and pre-enabled
// - Pad 9 mux code 0011 gives internal 32k
// - Pad 8 mux code 0010 gives crystal 32M
// - Pad 7 internal 32M, pad 6 crystal 32k
// - Re-route codes pick pads 4..10 skipping own
// - Re-routed signal stays on its original pad
// - Transmit synth integer and fraction words, reset 0
// - Receive synth integer and fraction words, reset 0
// - Bit 0 selects high low-noise amplifier gain
// - Eight-bit transmit power, 0x14 maximum; higher codes are stored as written
// - Four-bit transmit tune trim to tank
module rtm_core (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire rtm_pkg::rtm_wb_req_type wb_req,
  output rtm_pkg::rtm_wb_rsp_type    wb_rsp,
  input  wire logic                  test_access_pin,
  input  wire logic [10:0]           normal_func_en,
  input  wire logic                  osc_int_32k,
  input  wire logic                  osc_xtal_32m,
  input  wire logic                  osc_int_32m,
  input  wire logic                  osc_xtal_32k,
  output rtm_pkg::rtm_synth_type     tx_synth,
  output rtm_pkg::rtm_synth_type     rx_synth,
  output logic                       lna_high_gain,
  output logic [7:0]                 tx_power,
  output logic [3:0]                 tx_tune_trim,
  output logic [10:0]                func_en,
  output logic [6:0]                 general_pad_out,
  output logic [6:0]                 general_pad_test_en
);

  function automatic logic [31:0] rtm_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // Destination pad number of a re-route code, zero for none
  function automatic logic [3:0] rtm_dest(
    input logic [3:0] own_pad,
    input logic [2:0] code
  );
    logic [3:0] d;
    d = 4'h0;
    if (code != rtm_pkg::RTM_RR_NONE && code != rtm_pkg::RTM_RR_BAD) begin
      d = {1'b0, code} + rtm_pkg::RTM_RR_OFFSET;
      if (d >= own_pad) begin
        d = d + 4'h1;
      end
    end
    return d;
  endfunction

  logic [31:0]           tx_synth_words;
  logic [31:0]           rx_synth_words;
  logic [31:0]           rx_gain_control;
  logic [31:0]           tx_power_level;
  logic [31:0]           tx_tune_trim_reg;
  logic [31:0]           test_unlock_key;
  logic [31:0]           override_pre_enable;
  logic [31:0]           override_values;
  logic [31:0]           pad_test_signal_mux;
  logic [31:0]           pad_reroute_select;
  rtm_pkg::rtm_lock_type lock_state;
  rtm_pkg::rtm_lock_type next_lock_state;
  logic                  ack;

  // Bus decode
  wire        bus_req      = wb_req.cyc & wb_req.stb & ~ack;
  // Writes land at the edge where the master samples ack, while it still holds the request
  wire        bus_wr       = wb_req.cyc & wb_req.stb & wb_req.we & ack;
  wire        hit_tx_synth = wb_req.adr == rtm_pkg::RTM_ADR_TX_SYNTH;
  wire        hit_rx_synth = wb_req.adr == rtm_pkg::RTM_ADR_RX_SYNTH;
  wire        hit_rx_gain  = wb_req.adr == rtm_pkg::RTM_ADR_RX_GAIN;
  wire        hit_tx_power = wb_req.adr == rtm_pkg::RTM_ADR_TX_POWER;
  wire        hit_tx_trim  = wb_req.adr == rtm_pkg::RTM_ADR_TX_TRIM;
  wire        hit_unlock   = wb_req.adr == rtm_pkg::RTM_ADR_UNLOCK;
  wire        hit_pre_en   = wb_req.adr == rtm_pkg::RTM_ADR_PRE_EN;
  wire        hit_ovr_val  = wb_req.adr == rtm_pkg::RTM_ADR_OVR_VAL;
  wire        hit_stat     = wb_req.adr == rtm_pkg::RTM_ADR_LOCK_STAT;
  wire        hit_mux      = wb_req.adr == rtm_pkg::RTM_ADR_TEST_MUX;
  wire        hit_reroute  = wb_req.adr == rtm_pkg::RTM_ADR_REROUTE;
  wire        is_unlocked  = lock_state == rtm_pkg::rtm_unlocked;
  // Unlock is judged on the state before this write takes effect
  wire        test_wr_ok   = test_access_pin & is_unlocked;
  wire [31:0] key_written  = rtm_merge(test_unlock_key, wb_req.dat, wb_req.sel, '1);
  wire        key_match    = key_written == rtm_pkg::RTM_UNLOCK_KEY;
  wire        key_accept   = bus_wr & hit_unlock & key_match & test_access_pin;

  wire [31:0] status_word  = {30'h0, test_access_pin, is_unlocked};

  wire [31:0] read_data =
    hit_tx_synth ? tx_synth_words      :
    hit_rx_synth ? rx_synth_words      :
    hit_rx_gain  ? rx_gain_control     :
    hit_tx_power ? tx_power_level      :
    hit_tx_trim  ? tx_tune_trim_reg    :
    hit_unlock   ? test_unlock_key     :
    hit_pre_en   ? override_pre_enable :
    hit_ovr_val  ? override_values     :
    hit_stat     ? status_word         :
    hit_mux      ? pad_test_signal_mux :
    hit_reroute  ? pad_reroute_select  :
    32'h00000000;

  // Lock state
  always_comb begin
    next_lock_state = lock_state;
    unique case (lock_state)
      rtm_pkg::rtm_locked: begin
        if (key_accept) begin
          next_lock_state = rtm_pkg::rtm_unlocked;
        end
      end
      rtm_pkg::rtm_unlocked: begin
        // Wrong keys while unlocked are ignored, as in the locked state
        if (!test_access_pin) begin
          next_lock_state = rtm_pkg::rtm_locked;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_state <= rtm_pkg::rtm_locked;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // Bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack        <= 1'b0;
      wb_rsp.ack <= 1'b0;
      wb_rsp.dat <= 32'h00000000;
    end else begin
      ack        <= bus_req;
      wb_rsp.ack <= bus_req;
      wb_rsp.dat <= bus_req ? read_data : 32'h00000000;
    end
  end

  // RF settings, always writable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_synth_words <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_tx_synth) begin
      tx_synth_words <= rtm_merge(tx_synth_words, wb_req.dat, wb_req.sel, '1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_synth_words <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_rx_synth) begin
      rx_synth_words <= rtm_merge(rx_synth_words, wb_req.dat, wb_req.sel, '1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_gain_control <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_rx_gain) begin
      rx_gain_control <= rtm_merge(rx_gain_control, wb_req.dat, wb_req.sel,
                                   rtm_pkg::RTM_MASK_GAIN);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_power_level <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_tx_power) begin
      // Codes above the maximum are stored as written
      tx_power_level <= rtm_merge(tx_power_level, wb_req.dat, wb_req.sel,
                                  rtm_pkg::RTM_MASK_POWER);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_tune_trim_reg <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_tx_trim) begin
      tx_tune_trim_reg <= rtm_merge(tx_tune_trim_reg, wb_req.dat, wb_req.sel,
                                    rtm_pkg::RTM_MASK_TRIM);
    end
  end

  // Key register keeps whatever was last written; only the lock state matters
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      test_unlock_key <= rtm_pkg::RTM_RST_UNLOCK;
    end else if (bus_wr && hit_unlock) begin
      test_unlock_key <= key_written;
    end
  end

  // Guarded test registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      override_pre_enable <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_pre_en && test_wr_ok) begin
      override_pre_enable <= rtm_merge(override_pre_enable, wb_req.dat, wb_req.sel,
                                       rtm_pkg::RTM_MASK_FUNC);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      override_values <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_ovr_val && test_wr_ok) begin
      override_values <= rtm_merge(override_values, wb_req.dat, wb_req.sel,
                                   rtm_pkg::RTM_MASK_FUNC);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_test_signal_mux <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_mux && test_wr_ok) begin
      pad_test_signal_mux <= rtm_merge(pad_test_signal_mux, wb_req.dat, wb_req.sel,
                                       rtm_pkg::RTM_MASK_MUX);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_reroute_select <= rtm_pkg::RTM_RST_ZERO;
    end else if (bus_wr && hit_reroute && test_wr_ok) begin
      pad_reroute_select <= rtm_merge(pad_reroute_select, wb_req.dat, wb_req.sel,
                                      rtm_pkg::RTM_MASK_REROUTE);
    end
  end

  // Function enables: override only when unlocked and pre-enabled
  wire [10:0] ovr_active = override_pre_enable[10:0] & {11{is_unlocked}};
  wire [10:0] next_func_en = (ovr_active & override_values[10:0]) |
                             (~ovr_active & normal_func_en);

  // Test-mux sources, index 0..3 for pads 6..9
  wire [3:0] mux_code [rtm_pkg::RTM_SRC_CNT];
  wire [2:0] rr_code  [rtm_pkg::RTM_SRC_CNT];
  wire [3:0] src_on;
  wire [3:0] src_val = {osc_int_32k, osc_xtal_32m, osc_int_32m, osc_xtal_32k};

  for (genvar s = 0; s < rtm_pkg::RTM_SRC_CNT; s++) begin : g_src
    assign mux_code[s] = pad_test_signal_mux[rtm_pkg::RTM_MUX6_LSB + s*rtm_pkg::RTM_MUX_W +: rtm_pkg::RTM_MUX_W];
    assign rr_code[s]  = pad_reroute_select[rtm_pkg::RTM_RR6_LSB + s*rtm_pkg::RTM_RR_W +: rtm_pkg::RTM_RR_W];
  end

  assign src_on[3] = is_unlocked & (mux_code[3] == rtm_pkg::RTM_MUX9_CLK);
  assign src_on[2] = is_unlocked & (mux_code[2] == rtm_pkg::RTM_MUX_CLK);
  assign src_on[1] = is_unlocked & (mux_code[1] == rtm_pkg::RTM_MUX_CLK);
  assign src_on[0] = is_unlocked & (mux_code[0] == rtm_pkg::RTM_MUX_CLK);

  logic [6:0] next_pad_en;
  logic [6:0] next_pad_val;

  // Overlapping routes onto one pad are ORed; software should avoid that
  always_comb begin
    logic [3:0] own;
    logic [3:0] pad_num;
    logic [3:0] dest;
    own     = 4'h0;
    pad_num = 4'h0;
    dest    = 4'h0;
    next_pad_en  = 7'h00;
    next_pad_val = 7'h00;
    for (int p = 0; p < rtm_pkg::RTM_PAD_CNT; p++) begin
      pad_num = 4'(p + rtm_pkg::RTM_PAD_FIRST);
      for (int s = 0; s < rtm_pkg::RTM_SRC_CNT; s++) begin
        own  = rtm_pkg::RTM_PAD_BASE + 4'(s);
        dest = rtm_dest(own, rr_code[s]);
        if (src_on[s] && (own == pad_num || dest == pad_num)) begin
          next_pad_en[p]  = 1'b1;
          next_pad_val[p] = next_pad_val[p] | src_val[s];
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      func_en             <= 11'h000;
      general_pad_out     <= 7'h00;
      general_pad_test_en <= 7'h00;
    end else begin
      func_en             <= next_func_en;
      general_pad_out     <= next_pad_val;
      general_pad_test_en <= next_pad_en;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_synth      <= '0;
      rx_synth      <= '0;
      lna_high_gain <= 1'b0;
      tx_power      <= 8'h00;
      tx_tune_trim  <= 4'h0;
    end else begin
      tx_synth      <= tx_synth_words;
      rx_synth      <= rx_synth_words;
      lna_high_gain <= rx_gain_control[0];
      tx_power      <= tx_power_level[7:0];
      tx_tune_trim  <= tx_tune_trim_reg[3:0];
    end
  end

endmodule

// File: rtm_pkg.sv
// Constants and carrier types for the RF trim and test-mode register block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package rtm_pkg;

  // Register byte addresses
  localparam logic [31:0] RTM_ADR_TX_SYNTH   = 32'h40019000;
  localparam logic [31:0] RTM_ADR_RX_SYNTH   = 32'h40019004;
  localparam logic [31:0] RTM_ADR_RX_GAIN    = 32'h4001900C;
  localparam logic [31:0] RTM_ADR_TX_POWER   = 32'h40019010;
  localparam logic [31:0] RTM_ADR_TX_TRIM    = 32'h40019094;
  localparam logic [31:0] RTM_ADR_UNLOCK     = 32'h4001F000;
  localparam logic [31:0] RTM_ADR_PRE_EN     = 32'h4001F004;
  localparam logic [31:0] RTM_ADR_OVR_VAL    = 32'h4001F008;
  localparam logic [31:0] RTM_ADR_LOCK_STAT  = 32'h4001F00C;
  localparam logic [31:0] RTM_ADR_TEST_MUX   = 32'h4001F100;
  localparam logic [31:0] RTM_ADR_REROUTE    = 32'h4001F128;

  // Reset values and the unlock key
  localparam logic [31:0] RTM_RST_ZERO       = 32'h00000000;
  localparam logic [31:0] RTM_RST_UNLOCK     = 32'hA1313F21;
  localparam logic [31:0] RTM_UNLOCK_KEY     = 32'h5ECEC0DE;

  // Writable-bit masks; all other bits read as zero
  localparam logic [31:0] RTM_MASK_GAIN      = 32'h00000001;
  localparam logic [31:0] RTM_MASK_POWER     = 32'h000000FF;
  localparam logic [31:0] RTM_MASK_TRIM      = 32'h0000000F;
  localparam logic [31:0] RTM_MASK_FUNC      = 32'h000005EF;
  localparam logic [31:0] RTM_MASK_MUX       = 32'h0FFFF000;
  localparam logic [31:0] RTM_MASK_REROUTE   = 32'h0003FFC0;

  // Field positions
  localparam int RTM_INT_LSB        = 24;
  localparam int RTM_INT_W          = 8;
  localparam int RTM_FRAC_W         = 24;
  localparam int RTM_FUNC_W         = 11;
  localparam int RTM_MUX_W          = 4;
  localparam int RTM_MUX6_LSB       = 12;
  localparam int RTM_RR_W           = 3;
  localparam int RTM_RR6_LSB        = 6;
  localparam int RTM_STAT_UNLOCKED  = 0;
  localparam int RTM_STAT_PIN       = 1;

  // Pad numbering of the test outputs (pads 4 to 10)
  localparam int          RTM_PAD_FIRST = 4;
  localparam int          RTM_PAD_CNT   = 7;
  localparam int          RTM_SRC_CNT   = 4;
  localparam logic [3:0]  RTM_PAD_BASE  = 4'h6;

  // Mux codes that select an oscillator clock
  localparam logic [3:0]  RTM_MUX9_CLK  = 4'h3;
  localparam logic [3:0]  RTM_MUX_CLK   = 4'h2;

  // Re-route codes
  localparam logic [2:0]  RTM_RR_NONE   = 3'h0;
  localparam logic [2:0]  RTM_RR_BAD    = 3'h7;
  localparam logic [3:0]  RTM_RR_OFFSET = 4'h3;

  typedef enum logic {rtm_locked, rtm_unlocked} rtm_lock_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rtm_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } rtm_wb_rsp_type;

  typedef struct packed {
    logic [7:0]  int_word;
    logic [23:0] frac_word;
  } rtm_synth_type;

endpackage

// File: rtm_core_props.sv
// Concurrent checks on the ports of the RF trim and test-mode register block.
// Bound to rtm_core; sees only its ports, all in the one clock domain.
`timescale 1ns/100ps
module rtm_core_props (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire rtm_pkg::rtm_wb_req_type wb_req,
  input wire rtm_pkg::rtm_wb_rsp_type wb_rsp,
  input wire logic                    test_access_pin,
  input wire logic [10:0]             normal_func_en,
  input wire rtm_pkg::rtm_synth_type  tx_synth,
  input wire rtm_pkg::rtm_synth_type  rx_synth,
  input wire logic                    lna_high_gain,
  input wire logic [7:0]              tx_power,
  input wire logic [3:0]              tx_tune_trim,
  input wire logic [10:0]             func_en,
  input wire logic [6:0]              general_pad_test_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire logic take    = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  // A write lands at the ack edge; partial-lane writes are left out so the full word can be compared
  wire logic wr_full = wb_rsp.ack && wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel == 4'hF;

  a_ack_after_take: assert property (take |=> wb_rsp.ack)
    else $error("ack missing after a taken request");
  a_ack_one_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  a_idle_data_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == '0)
    else $error("read data not zero outside ack");
  a_tx_words_write: assert property (
    wr_full && wb_req.adr == rtm_pkg::RTM_ADR_TX_SYNTH |-> ##2 tx_synth == $past(wb_req.dat, 2))
    else $error("tx synth words not taken from write");
  a_rx_words_write: assert property (
    wr_full && wb_req.adr == rtm_pkg::RTM_ADR_RX_SYNTH |-> ##2 rx_synth == $past(wb_req.dat, 2))
    else $error("rx synth words not taken from write");
  a_gain_bit_write: assert property (
    wr_full && wb_req.adr == rtm_pkg::RTM_ADR_RX_GAIN |-> ##2 lna_high_gain == $past(wb_req.dat[0], 2))
    else $error("gain bit not taken from write");
  a_power_field_write: assert property (
    wr_full && wb_req.adr == rtm_pkg::RTM_ADR_TX_POWER |-> ##2 tx_power == $past(wb_req.dat[7:0], 2))
    else $error("power field not taken from write");
  a_trim_field_write: assert property (
    wr_full && wb_req.adr == rtm_pkg::RTM_ADR_TX_TRIM |-> ##2 tx_tune_trim == $past(wb_req.dat[3:0], 2))
    else $error("trim field not taken from write");
  a_unowned_bits_normal: assert property ($past(rst_n) |->
    func_en[4] == $past(normal_func_en[4]) && func_en[9] == $past(normal_func_en[9]))
    else $error("bits without override left normal control");
  a_locked_func_normal: assert property (
    (!test_access_pin)[*3] ##0 $past(rst_n) |-> func_en == $past(normal_func_en))
    else $error("override active while locked");
  a_locked_pads_quiet: assert property (
    (!test_access_pin)[*3] |-> general_pad_test_en == '0)
    else $error("test pad driven while locked");
endmodule

// File: rtm_core_tb_top.sv
// Self-checking bench for the RF trim and test-mode register block.
// The bench is the Wishbone master and drives pin and oscillator levels.
`timescale 1ns/100ps
module rtm_core_tb_top;
  logic                    clock;
  logic                    rst_n;
  rtm_pkg::rtm_wb_req_type wb_req;
  rtm_pkg::rtm_wb_rsp_type wb_rsp;
  logic                    test_access_pin;
  logic [10:0]             normal_func_en;
  logic [3:0]              osc;
  rtm_pkg::rtm_synth_type  tx_synth;
  rtm_pkg::rtm_synth_type  rx_synth;
  logic                    lna_high_gain;
  logic [7:0]              tx_power;
  logic [3:0]              tx_tune_trim;
  logic [10:0]             func_en;
  logic [6:0]              general_pad_out;
  logic [6:0]              general_pad_test_en;
  logic [31:0]             rdat;
  logic [31:0]             zadr [10];
  logic [6:0]              m;
  int                      failures;
  int                      compares;

  rtm_core dut_u (.clock(clock), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .test_access_pin(test_access_pin), .normal_func_en(normal_func_en), .osc_int_32k(osc[0]),
    .osc_xtal_32m(osc[1]), .osc_int_32m(osc[2]), .osc_xtal_32k(osc[3]), .tx_synth(tx_synth),
    .rx_synth(rx_synth), .lna_high_gain(lna_high_gain), .tx_power(tx_power), .tx_tune_trim(tx_tune_trim),
    .func_en(func_en), .general_pad_out(general_pad_out), .general_pad_test_en(general_pad_test_en));

  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Holds the request until ack is sampled; there is no fixed answer time
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do @(posedge clock); while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask

  task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    chk(rdat, exp);
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    tick(3000);
    failures++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    wb_req = '0;
    test_access_pin = 1'b0;
    normal_func_en = 11'h211;
    osc = 4'h0;
    failures = 0;
    compares = 0;
    zadr = '{rtm_pkg::RTM_ADR_TX_SYNTH, rtm_pkg::RTM_ADR_RX_SYNTH, rtm_pkg::RTM_ADR_RX_GAIN,
      rtm_pkg::RTM_ADR_TX_POWER, rtm_pkg::RTM_ADR_TX_TRIM, rtm_pkg::RTM_ADR_PRE_EN,
      rtm_pkg::RTM_ADR_OVR_VAL, rtm_pkg::RTM_ADR_TEST_MUX, rtm_pkg::RTM_ADR_REROUTE, 32'h40019008};
    tick(6);
    rst_n <= 1'b1;
    foreach (zadr[i]) rd_chk(zadr[i], 32'h0);
    rd_chk(rtm_pkg::RTM_ADR_UNLOCK, 32'hA1313F21);
    chk(func_en, 32'h211);
    // Tone wanted at 2400.5 MHz: 500 kHz is added before the words are worked out
    wr(rtm_pkg::RTM_ADR_TX_SYNTH, 32'h4B002000);
    rd_chk(rtm_pkg::RTM_ADR_TX_SYNTH, 32'h4B002000);
    chk(tx_synth, 32'h4B002000);
    wr(rtm_pkg::RTM_ADR_RX_SYNTH, 32'hA5C30F96);
    tick(2);
    chk(rx_synth, 32'hA5C30F96);
    wr(rtm_pkg::RTM_ADR_RX_GAIN, 32'hFFFFFFFF);
    rd_chk(rtm_pkg::RTM_ADR_RX_GAIN, 32'h1);
    chk(lna_high_gain, 32'h1);
    wr(rtm_pkg::RTM_ADR_TX_POWER, 32'hFFFFFF14);
    rd_chk(rtm_pkg::RTM_ADR_TX_POWER, 32'h14);
    chk(tx_power, 32'h14);
    wr(rtm_pkg::RTM_ADR_TX_TRIM, 32'hFFFFFFFA);
    rd_chk(rtm_pkg::RTM_ADR_TX_TRIM, 32'hA);
    chk(tx_tune_trim, 32'hA);
    // Key with the pin low, then a near-miss key with the pin high
    wr(rtm_pkg::RTM_ADR_UNLOCK, rtm_pkg::RTM_UNLOCK_KEY);
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'h1C2);
    rd_chk(rtm_pkg::RTM_ADR_PRE_EN, 32'h0);
    test_access_pin <= 1'b1;
    wr(rtm_pkg::RTM_ADR_UNLOCK, 32'h5ECEC0DF);
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'h1C2);
    rd_chk(rtm_pkg::RTM_ADR_PRE_EN, 32'h0);
    rd_chk(rtm_pkg::RTM_ADR_LOCK_STAT, 32'h2);
    wr(rtm_pkg::RTM_ADR_UNLOCK, rtm_pkg::RTM_UNLOCK_KEY);
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'hFFFFFFFF);
    rd_chk(rtm_pkg::RTM_ADR_PRE_EN, 32'h5EF);
    rd_chk(rtm_pkg::RTM_ADR_LOCK_STAT, 32'h3);
    wr(rtm_pkg::RTM_ADR_OVR_VAL, 32'hFFFFFFFF);
    rd_chk(rtm_pkg::RTM_ADR_OVR_VAL, 32'h5EF);
    chk(func_en, 32'h7FF);
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'h1C2);
    wr(rtm_pkg::RTM_ADR_OVR_VAL, 32'h0C3);
    tick(2);
    chk(func_en, 32'h2D3);
    wr(rtm_pkg::RTM_ADR_TEST_MUX, 32'hF3222FFF);
    rd_chk(rtm_pkg::RTM_ADR_TEST_MUX, 32'h03222000);
    chk(general_pad_test_en, 32'h3C);
    for (int i = 0; i < 4; i++) begin
      osc <= 4'(1 << i);
      tick(2);
      chk(general_pad_out, 32'h20 >> i);
    end
    osc <= 4'h1;
    for (int c = 0; c < 7; c++) begin
      m = (c == 6) ? 7'h40 : (c == 0) ? 7'h0 : 7'(1 << (c - 1));
      wr(rtm_pkg::RTM_ADR_REROUTE, 32'(c) << 15);
      tick(2);
      chk(general_pad_out, 32'h20 | m);
      chk(general_pad_test_en, 32'h3C | m);
    end
    test_access_pin <= 1'b0;
    tick(3);
    chk(func_en, 32'h211);
    chk(general_pad_test_en, 32'h0);
    test_access_pin <= 1'b1;
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'h0);
    rd_chk(rtm_pkg::RTM_ADR_PRE_EN, 32'h1C2);
    wr(rtm_pkg::RTM_ADR_TEST_MUX, 32'h0);
    wr(rtm_pkg::RTM_ADR_REROUTE, 32'h0);
    rd_chk(rtm_pkg::RTM_ADR_TEST_MUX, 32'h03222000);
    rd_chk(rtm_pkg::RTM_ADR_REROUTE, 32'h00030000);
    rd_chk(rtm_pkg::RTM_ADR_LOCK_STAT, 32'h2);
    wr(rtm_pkg::RTM_ADR_UNLOCK, rtm_pkg::RTM_UNLOCK_KEY);
    tick(2);
    chk(func_en, 32'h2D3);
    // New tone: drop the pre-enables, change the words, then enable again
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'h0);
    tick(2);
    chk(func_en, 32'h211);
    wr(rtm_pkg::RTM_ADR_TX_SYNTH, 32'h4B004000);
    wr(rtm_pkg::RTM_ADR_OVR_VAL, 32'h1C2);
    wr(rtm_pkg::RTM_ADR_PRE_EN, 32'h1C2);
    tick(2);
    chk(func_en, 32'h3D3);
    chk(tx_synth, 32'h4B004000);
    test_done();
  end
endmodule

bind rtm_core rtm_core_props rtm_core_props_u (.clock(clock), .rst_n(rst_n), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .test_access_pin(test_access_pin), .normal_func_en(normal_func_en),
  .tx_synth(tx_synth), .rx_synth(rx_synth), .lna_high_gain(lna_high_gain), .tx_power(tx_power),
  .tx_tune_trim(tx_tune_trim), .func_en(func_en), .general_pad_test_en(general_pad_test_en));
